// ---- rtl/fms_map.svh ----
// Purpose: register offsets, field positions, reset values and counts
// Assumes: 32-bit classic Wishbone, word-aligned registers
// Notes: included by the supervisor only
`ifndef FMS_MAP_SVH
`define FMS_MAP_SVH
// Register byte offsets
`define FMS_REG_CFG 8'h00
`define FMS_REG_EFREQ 8'h04
`define FMS_REG_NFREQ 8'h08
`define FMS_REG_RAMP 8'h0c
`define FMS_REG_RETRY 8'h10
`define FMS_REG_OUTSEL 8'h14
`define FMS_REG_CMD 8'h18
`define FMS_REG_STATUS 8'h1c
`define FMS_REG_FAULT 8'h20
`define FMS_REG_EFFECT 8'h24
// Field positions
`define FMS_CMD_RESET_BIT 0
`define FMS_CMD_INIT_BIT 1
`define FMS_ST_MODE_BIT 0
`define FMS_ST_EVID_BIT 1
`define FMS_ST_INHIBIT_BIT 2
`define FMS_ST_FAULT_BIT 3
`define FMS_ST_CODE_LSB 8
// Reset and limit values
`define FMS_EFREQ_DEFAULT 16'h1388
`define FMS_EFREQ_MAX 16'h9c40
`define FMS_RAMP_FIXED 16'h0064
`define FMS_ACC_DEFAULT 16'h0032
`define FMS_DEC_DEFAULT 16'h0032
`define FMS_RETRY_DLY_DEFAULT 16'h03e8
`define FMS_RETRY_CNT_DEFAULT 8'h00
`define FMS_SEL_FAULT 5'h11
`define FMS_SEL_FAN 5'h12
`define FMS_MO_SEL_DEFAULT 5'h0c
`define FMS_RELAY_SEL_DEFAULT 5'h11
`define FMS_METHOD_DEFAULT 2'h0
// Trip classes, one bit per trip source
`define FMS_TRIP_FAN 8
`define FMS_MASKED_SET 16'h01ff
`define FMS_RECOVER_SET 16'h1e00
`define FMS_FATAL_SET 16'he000
// Time base: retry delay counted in milliseconds
`define FMS_CLK_HZ 25000000
`define FMS_MS_PER_S 1000
`endif

// ---- rtl/fms_pkg.sv ----
// Purpose: shared types of the emergency-mode supervisor
// Assumes: nothing beyond the map header
// Notes: control methods and retry states
package fms_pkg;
    typedef enum logic [1:0] {
        FMS_VF = 2'h0,
        FMS_SLIP = 2'h1,
        FMS_PID = 2'h2,
        FMS_SENSORLESS = 2'h3
    } fms_method_type;

    typedef enum logic {
        FMS_RT_IDLE,
        FMS_RT_WAIT
    } fms_retry_type;
endpackage : fms_pkg

// ---- rtl/fms_supervisor.sv ----
// Purpose: emergency operation supervisor with Wishbone register file
// Assumes: one 25 MHz clock, trips and pins asynchronous to it
// Notes: only a power-on reset leaves emergency mode
`include "fms_map.svh"
`timescale 1ns/100ps
`default_nettype none
module fms_supervisor
    import fms_pkg::*;
#(
    parameter int MS_CYCLES = `FMS_CLK_HZ / `FMS_MS_PER_S,
    parameter int TRIPS = 16
) (
    input wire logic ref_clk,
    input wire logic rstn,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Pins from the outside world
    input wire logic emergency_in,
    input wire logic run_cmd_in,
    input wire logic [TRIPS-1:0] trip_in,
    // Toward the power stage and the terminals
    output logic run_enable,
    output logic [1:0] ctrl_method,
    output logic [15:0] freq_ref,
    output logic [15:0] acc_time,
    output logic [15:0] dec_time,
    output logic mf_output,
    output logic mf_relay
);
    // Lowest set bit index, used for the trip code
    function automatic logic [3:0] first_set(input logic [TRIPS-1:0] v);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = TRIPS - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = i[3:0];
            end
        end
        return idx;
    endfunction : first_set

    // Selected terminal function
    function automatic logic sel_out(input logic [4:0] sel, input logic flt,
                                     input logic fan);
        return (sel == `FMS_SEL_FAULT) ? flt : ((sel == `FMS_SEL_FAN) ? fan : 1'b0);
    endfunction : sel_out

    logic [1:0] emerg_sync_ff, run_sync_ff, method_ff, method_out_ff;
    logic [TRIPS-1:0] trip_meta_ff, trip_sync_ff, fault_ff, pre_ff;
    logic [3:0] code_ff;
    logic [15:0] efreq_ff, nfreq_ff, acc_ff, dec_ff, eref_ff, retry_dly_ff;
    logic [15:0] dly_cnt_ff, freq_out_ff, acc_out_ff, dec_out_ff;
    logic [7:0] retry_cnt_ff, retries_left_ff;
    logic [4:0] mo_sel_ff, relay_sel_ff;
    fms_retry_type rt_state_ff;
    logic [31:0] ms_cnt_ff, rdata_ff;
    logic mode_ff, evid_ff, ack_ff, run_ff, mo_ff, relay_ff;

    // Bus decode
    wire req = wb_cyc_i && wb_stb_i && !ack_ff;
    wire wr = req && wb_we_i;
    wire lo_en = wb_sel_i[0];
    wire hi_en = wb_sel_i[1];
    wire wr_cfg = wr && (wb_adr_i == `FMS_REG_CFG) && lo_en;
    wire wr_efreq = wr && (wb_adr_i == `FMS_REG_EFREQ);
    wire wr_nfreq = wr && (wb_adr_i == `FMS_REG_NFREQ);
    wire wr_ramp = wr && (wb_adr_i == `FMS_REG_RAMP);
    wire wr_retry = wr && (wb_adr_i == `FMS_REG_RETRY);
    wire wr_outsel = wr && (wb_adr_i == `FMS_REG_OUTSEL);
    wire wr_cmd = wr && (wb_adr_i == `FMS_REG_CMD) && lo_en;
    wire sw_reset = wr_cmd && wb_dat_i[`FMS_CMD_RESET_BIT];
    wire sw_init = wr_cmd && wb_dat_i[`FMS_CMD_INIT_BIT];

    // Setpoint clamped at the top of its range
    wire [15:0] efreq_in = (wb_dat_i[15:0] > `FMS_EFREQ_MAX) ? `FMS_EFREQ_MAX
                                                              : wb_dat_i[15:0];

    // Fault classification
    wire [TRIPS-1:0] new_trip = trip_sync_ff & ~fault_ff;
    wire entering = emerg_sync_ff[1] && !mode_ff;
    wire [TRIPS-1:0] recover_set = `FMS_RECOVER_SET;
    wire [TRIPS-1:0] fatal_set = `FMS_FATAL_SET;
    wire any_fault = |fault_ff;
    wire fatal_hit = |(fault_ff & fatal_set);
    wire recover_hit = |(fault_ff & recover_set);
    wire fan_fault = fault_ff[`FMS_TRIP_FAN];
    wire retry_allowed = mode_ff || (retries_left_ff != 8'h00);
    wire retry_done = (rt_state_ff == FMS_RT_WAIT) && (dly_cnt_ff >= retry_dly_ff)
                      && recover_hit;
    wire [TRIPS-1:0] retry_clr = retry_done ? recover_set : '0;
    // Pre-mode alarms stay latched; fatal ones too while in the mode
    wire [TRIPS-1:0] reset_mask = mode_ff ? ~(pre_ff | fatal_set) : '1;
    wire [TRIPS-1:0] sw_clr = sw_reset ? reset_mask : '0;
    wire [TRIPS-1:0] nxt_fault = (fault_ff & ~(sw_clr | retry_clr)) | trip_sync_ff;

    // Drive permission: masked trips never stop the mode
    wire nxt_run = mode_ff ? (!fatal_hit && !recover_hit)
                           : (run_sync_ff[1] && !any_fault);
    wire [1:0] nxt_method = mode_ff ? FMS_VF : method_ff;
    wire [15:0] nxt_freq = mode_ff ? eref_ff : nfreq_ff;
    wire [15:0] nxt_acc = mode_ff ? `FMS_RAMP_FIXED : acc_ff;
    wire [15:0] nxt_dec = mode_ff ? `FMS_RAMP_FIXED : dec_ff;

    // Read mux; unmapped offsets read zero
    wire [31:0] status_word = {16'h0000, 4'h0, code_ff, 4'h0, any_fault, fatal_hit,
                               evid_ff, mode_ff};
    wire [31:0] nxt_rdata =
        (wb_adr_i == `FMS_REG_CFG) ? {30'h0, method_ff} :
        (wb_adr_i == `FMS_REG_EFREQ) ? {16'h0, efreq_ff} :
        (wb_adr_i == `FMS_REG_NFREQ) ? {16'h0, nfreq_ff} :
        (wb_adr_i == `FMS_REG_RAMP) ? {dec_ff, acc_ff} :
        (wb_adr_i == `FMS_REG_RETRY) ? {8'h0, retry_cnt_ff, retry_dly_ff} :
        (wb_adr_i == `FMS_REG_OUTSEL) ? {19'h0, relay_sel_ff, 3'h0, mo_sel_ff} :
        (wb_adr_i == `FMS_REG_STATUS) ? status_word :
        (wb_adr_i == `FMS_REG_FAULT) ? {16'h0, fault_ff} :
        (wb_adr_i == `FMS_REG_EFFECT) ? {freq_out_ff, 14'h0, method_out_ff} :
        32'h0;

    // Two-flop synchronisers for every pin
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            emerg_sync_ff <= 2'h0;
            run_sync_ff <= 2'h0;
            trip_meta_ff <= '0;
            trip_sync_ff <= '0;
        end else begin
            emerg_sync_ff <= {emerg_sync_ff[0], emergency_in};
            run_sync_ff <= {run_sync_ff[0], run_cmd_in};
            trip_meta_ff <= trip_in;
            trip_sync_ff <= trip_meta_ff;
        end
    end

    // Mode latch; only the power-on reset clears it
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mode_ff <= 1'b0;
            pre_ff <= '0;
        end else begin
            mode_ff <= mode_ff || emerg_sync_ff[1];
            if (entering) begin
                pre_ff <= fault_ff;
            end
        end
    end

    // Evidence flag: no software path clears it
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            evid_ff <= 1'b0;
        end else if (mode_ff && (|new_trip)) begin
            evid_ff <= 1'b1;
        end
    end

    // Fault latch with trip code; a new trip beats a clear
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            fault_ff <= '0;
            code_ff <= 4'h0;
        end else begin
            fault_ff <= nxt_fault;
            if (|new_trip) begin
                code_ff <= first_set(new_trip);
            end
        end
    end

    // Auto-retry delay in milliseconds; unlimited in the mode
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rt_state_ff <= FMS_RT_IDLE;
            ms_cnt_ff <= 32'h0;
            dly_cnt_ff <= 16'h0;
            retries_left_ff <= `FMS_RETRY_CNT_DEFAULT;
        end else begin
            unique case (rt_state_ff)
                FMS_RT_IDLE: begin
                    ms_cnt_ff <= 32'h0;
                    dly_cnt_ff <= 16'h0;
                    if (recover_hit && retry_allowed && !fatal_hit) begin
                        rt_state_ff <= FMS_RT_WAIT;
                    end
                end
                FMS_RT_WAIT: begin
                    if (!recover_hit || retry_done) begin
                        rt_state_ff <= FMS_RT_IDLE;
                    end else if (ms_cnt_ff == 32'(MS_CYCLES - 1)) begin
                        ms_cnt_ff <= 32'h0;
                        dly_cnt_ff <= dly_cnt_ff + 16'h1;
                    end else begin
                        ms_cnt_ff <= ms_cnt_ff + 32'h1;
                    end
                end
            endcase
            if (sw_reset || sw_init) begin
                retries_left_ff <= retry_cnt_ff;
            end else if (retry_done && !mode_ff) begin
                retries_left_ff <= retries_left_ff - 8'h1;
            end
        end
    end

    // Setpoint held while running in the mode
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            eref_ff <= `FMS_EFREQ_DEFAULT;
        end else if (entering || (mode_ff && !run_ff)) begin
            eref_ff <= efreq_ff;
        end
    end

    // Configuration registers; initialization restores defaults
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            method_ff <= `FMS_METHOD_DEFAULT;
            efreq_ff <= `FMS_EFREQ_DEFAULT;
            nfreq_ff <= 16'h0;
            acc_ff <= `FMS_ACC_DEFAULT;
            dec_ff <= `FMS_DEC_DEFAULT;
            retry_dly_ff <= `FMS_RETRY_DLY_DEFAULT;
            retry_cnt_ff <= `FMS_RETRY_CNT_DEFAULT;
            mo_sel_ff <= `FMS_MO_SEL_DEFAULT;
            relay_sel_ff <= `FMS_RELAY_SEL_DEFAULT;
        end else if (sw_init) begin
            method_ff <= `FMS_METHOD_DEFAULT;
            efreq_ff <= `FMS_EFREQ_DEFAULT;
            nfreq_ff <= 16'h0;
            acc_ff <= `FMS_ACC_DEFAULT;
            dec_ff <= `FMS_DEC_DEFAULT;
            retry_dly_ff <= `FMS_RETRY_DLY_DEFAULT;
            retry_cnt_ff <= `FMS_RETRY_CNT_DEFAULT;
            mo_sel_ff <= `FMS_MO_SEL_DEFAULT;
            relay_sel_ff <= `FMS_RELAY_SEL_DEFAULT;
        end else begin
            if (wr_cfg) begin
                method_ff <= wb_dat_i[1:0];
            end
            if (wr_efreq && lo_en && hi_en) begin
                efreq_ff <= efreq_in;
            end
            if (wr_nfreq && lo_en && hi_en) begin
                nfreq_ff <= wb_dat_i[15:0];
            end
            if (wr_ramp && lo_en && hi_en) begin
                acc_ff <= wb_dat_i[15:0];
            end
            if (wr_ramp && wb_sel_i[2] && wb_sel_i[3]) begin
                dec_ff <= wb_dat_i[31:16];
            end
            if (wr_retry && lo_en && hi_en) begin
                retry_dly_ff <= wb_dat_i[15:0];
            end
            if (wr_retry && wb_sel_i[2]) begin
                retry_cnt_ff <= wb_dat_i[23:16];
            end
            if (wr_outsel && lo_en) begin
                mo_sel_ff <= wb_dat_i[4:0];
            end
            if (wr_outsel && hi_en) begin
                relay_sel_ff <= wb_dat_i[12:8];
            end
        end
    end

    // Registered outputs toward the power stage and terminals
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            run_ff <= 1'b0;
            method_out_ff <= `FMS_METHOD_DEFAULT;
            freq_out_ff <= 16'h0;
            acc_out_ff <= `FMS_ACC_DEFAULT;
            dec_out_ff <= `FMS_DEC_DEFAULT;
            mo_ff <= 1'b0;
            relay_ff <= 1'b0;
        end else begin
            run_ff <= nxt_run;
            method_out_ff <= nxt_method;
            freq_out_ff <= nxt_freq;
            acc_out_ff <= nxt_acc;
            dec_out_ff <= nxt_dec;
            mo_ff <= sel_out(mo_sel_ff, any_fault, fan_fault);
            relay_ff <= sel_out(relay_sel_ff, any_fault, fan_fault);
        end
    end

    // Bus answer one cycle after the request
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ack_ff <= 1'b0;
            rdata_ff <= 32'h0;
        end else begin
            ack_ff <= req;
            rdata_ff <= req ? nxt_rdata : 32'h0;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdata_ff;
    assign run_enable = run_ff;
    assign ctrl_method = method_out_ff;
    assign freq_ref = freq_out_ff;
    assign acc_time = acc_out_ff;
    assign dec_time = dec_out_ff;
    assign mf_output = mo_ff;
    assign mf_relay = relay_ff;
endmodule : fms_supervisor
`default_nettype wire

// ---- testbench/fms_supervisor_props.sv ----
// Purpose: port-level checks of the emergency-mode supervisor
// Assumes: one 25 MHz ref_clk, asynchronous active-low rstn
// Notes: mode and fatal trips are tracked late on purpose, leaving slack for the pin sync
`timescale 1ns/100ps
`default_nettype none
module fms_supervisor_props
    import fms_pkg::*;
#(
    parameter int TRIPS = 16
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic emergency_in,
    input wire logic run_cmd_in,
    input wire logic [TRIPS-1:0] trip_in,
    input wire logic run_enable,
    input wire logic [1:0] ctrl_method,
    input wire logic [15:0] freq_ref,
    input wire logic [15:0] acc_time,
    input wire logic [15:0] dec_time,
    input wire logic mf_output,
    input wire logic mf_relay
);
    logic [5:0] em_ff;
    logic [5:0] ftl_ff;
    logic mode_ff;
    logic fatal_ff;

    // Delayed pin copies; sticky flags only, so a late view never misses an entry
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            em_ff <= 6'h00;
            ftl_ff <= 6'h00;
            mode_ff <= 1'b0;
            fatal_ff <= 1'b0;
        end else begin
            em_ff <= {em_ff[4:0], emergency_in};
            ftl_ff <= {ftl_ff[4:0], |trip_in[15:13]};
            mode_ff <= mode_ff | em_ff[5];
            fatal_ff <= fatal_ff | (mode_ff & ftl_ff[5]);
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    // Bus handshake
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked in the next cycle");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without a request");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    // Emergency mode outputs
    mode_vf_a: assert property (mode_ff |-> ctrl_method == FMS_VF)
        else $error("method not forced to V/F in mode");
    mode_ramp_a: assert property (mode_ff |-> acc_time == 16'h0064 && dec_time == 16'h0064)
        else $error("ramps not fixed in mode");
    freq_hold_a: assert property (mode_ff && run_enable && $past(run_enable)
        && $past(run_enable, 2) |-> $stable(freq_ref))
        else $error("frequency moved while running in mode");
    fatal_stop_a: assert property (fatal_ff |-> !run_enable)
        else $error("running after a fatal trip in mode");
    retry_drop_a: assert property (mode_ff && $rose(|trip_in[12:9]) |-> ##[1:6] !run_enable)
        else $error("recoverable trip did not pause the drive");

    cover property (mode_ff && run_enable);
    cover property (fatal_ff);
    cover property (wb_ack_o && wb_we_i);
endmodule : fms_supervisor_props
`default_nettype wire

// ---- testbench/fms_plant.sv ----
// Purpose: emergency contact and trip pins of the far side
// Assumes: requests from the bench, applied one clock later like real wiring
// Notes: pins are plain levels with no bounce
`timescale 1ns/100ps
`default_nettype none
module fms_plant (
    input wire logic ref_clk,
    input wire logic em_req,
    input wire logic [15:0] trip_req,
    output logic emergency_in,
    output logic [15:0] trip_in
);
    // Contact follows the request; it is opened before any power cycle
    always @(posedge ref_clk) begin
        emergency_in <= em_req;
        trip_in <= trip_req;
    end
endmodule : fms_plant
`default_nettype wire

// ---- testbench/test_fire_mode_trip_supervisor.sv ----
// Purpose: self-checking bench of the emergency-mode supervisor
// Assumes: MS_CYCLES of 4 so retry delays stay short
// Notes: reads queue their expectation; a monitor compares at ack
`timescale 1ns/100ps
`default_nettype none
module test_fire_mode_trip_supervisor;
    localparam int TRIPS = 16;
    logic ref_clk = 1'b0, rstn = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_wdat = 32'h0, wb_rdat;
    logic wb_ack, emergency_in, run_cmd_in = 1'b0, em_req = 1'b0, run_enable, mf_output, mf_relay;
    logic [15:0] trip_in, trip_req = 16'h0000, freq_ref, acc_time, dec_time;
    logic [1:0] ctrl_method;
    logic [63:0] exp_q[$];
    int errors = 0;
    int n_tests = 0;

    always #20 ref_clk = ~ref_clk;

    fms_supervisor #(.MS_CYCLES(4), .TRIPS(TRIPS)) i_fms_supervisor (.ref_clk(ref_clk),
        .rstn(rstn), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
        .emergency_in(emergency_in), .run_cmd_in(run_cmd_in), .trip_in(trip_in),
        .run_enable(run_enable), .ctrl_method(ctrl_method), .freq_ref(freq_ref),
        .acc_time(acc_time), .dec_time(dec_time), .mf_output(mf_output), .mf_relay(mf_relay));
    fms_plant i_fms_plant (.ref_clk(ref_clk), .em_req(em_req), .trip_req(trip_req),
        .emergency_in(emergency_in), .trip_in(trip_in));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic end_of_test;
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_of_test

    // One classic cycle; for reads d is the expected value under mask m
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
        input logic [31:0] m);
        int n = 0;
        @(posedge ref_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_sel <= 4'hf;
        wb_wdat <= we ? d : 32'h0;
        if (!we) exp_q.push_back({m, d});
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        if (n >= 50) errors++;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask : wb

    // Ends on a falling edge so outputs are settled when looked at
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : tick

    task automatic pins(input logic [15:0] v, input int n);
        @(posedge ref_clk);
        trip_req <= v;
        tick(n);
    endtask : pins

    // Bounded wait; the final compare reports a level that never came
    task automatic wait_run(input logic v);
        int n = 0;
        while (run_enable !== v && n < 300) begin
            @(negedge ref_clk);
            n++;
        end
        check(run_enable, v, "run_enable");
    endtask : wait_run

    // Read monitor: oldest note against the data returned with ack
    always @(posedge ref_clk) begin : mon
        logic [63:0] note;
        if (wb_ack === 1'b1 && wb_cyc && !wb_we) begin
            if (exp_q.size() == 0) errors++;
            else begin
                note = exp_q.pop_front();
                check(wb_rdat & note[63:32], note[31:0], "read data");
            end
        end
    end

    initial begin
        logic [15:0] r;
        void'($urandom(70774));
        repeat (8) @(posedge ref_clk);
        rstn <= 1'b1;
        wb(0, 8'h04, 32'h1388, 32'hffffffff);
        wb(0, 8'h0c, 32'h00320032, 32'hffffffff);
        wb(0, 8'h14, 32'h0000110c, 32'hffffffff);
        wb(0, 8'h1c, 32'h0, 32'hffffffff);
        wb(0, 8'h30, 32'h0, 32'hffffffff);
        wb(1, 8'h04, 32'hffff, 32'h0);
        wb(0, 8'h04, 32'h9c40, 32'hffffffff);
        r = 16'($urandom_range(40000));
        wb(1, 8'h04, {16'h0, r}, 32'h0);
        wb(0, 8'h04, {16'h0, r}, 32'hffffffff);
        // Normal mode settings that the mode must override
        wb(1, 8'h00, 32'h3, 32'h0);
        wb(1, 8'h08, 32'h0bb8, 32'h0);
        wb(1, 8'h0c, 32'h00c80096, 32'h0);
        wb(1, 8'h10, 32'h00000002, 32'h0);
        @(posedge ref_clk);
        run_cmd_in <= 1'b1;
        tick(8);
        check(ctrl_method, 2'h3, "ctrl_method");
        check(freq_ref, 16'h0bb8, "freq_ref");
        check(run_enable, 1'b1, "run_enable");
        // A trip latched before the mode must survive resets in it
        pins(16'h0001, 8);
        check(run_enable, 1'b0, "run_enable");
        pins(16'h0000, 4);
        @(posedge ref_clk);
        em_req <= 1'b1;
        tick(10);
        check(ctrl_method, 2'h0, "ctrl_method");
        check(freq_ref, r, "freq_ref");
        check({acc_time, dec_time}, 32'h00640064, "ramps");
        check(run_enable, 1'b1, "run_enable");
        @(posedge ref_clk);
        em_req <= 1'b0;
        run_cmd_in <= 1'b0;
        tick(10);
        wb(0, 8'h1c, 32'h9, 32'hf);
        wb(1, 8'h18, 32'h1, 32'h0);
        wb(0, 8'h20, 32'h1, 32'h1);
        // Masked trips 1 to 8 keep the drive running and raise the fault output
        wb(1, 8'h14, 32'h00001112, 32'h0);
        for (int i = 1; i <= 8; i++) begin
            pins(16'h0001 << i, 6);
            check(run_enable, 1'b1, "run_enable");
            check({mf_relay, mf_output}, {1'b1, i == 8}, "mf outputs");
            pins(16'h0000, 3);
        end
        wb(0, 8'h1c, 32'h080b, 32'h0f0f);
        wb(1, 8'h04, 32'h0fa0, 32'h0);
        wb(1, 8'h0c, 32'h00010001, 32'h0);
        tick(2);
        check(freq_ref, r, "freq_ref");
        check(acc_time, 16'h0064, "acc_time");
        wb(0, 8'h24, {r, 16'h0}, 32'hffff0003);
        // Recoverable trips retried without limit although the count is 0
        for (int i = 9; i <= 12; i++) begin
            pins(16'h0001 << i, 3);
            pins(16'h0000, 0);
            wait_run(1'b0);
            wait_run(1'b1);
        end
        wb(1, 8'h18, 32'h2, 32'h0);
        wb(0, 8'h04, 32'h1388, 32'hffffffff);
        wb(0, 8'h1c, 32'h3, 32'h3);
        pins(16'h2000, 6);
        check(run_enable, 1'b0, "run_enable");
        pins(16'h0000, 0);
        wb(1, 8'h18, 32'h1, 32'h0);
        tick(4);
        check(run_enable, 1'b0, "run_enable");
        wb(0, 8'h1c, 32'h4, 32'h4);
        // Power cycle with the contact open leaves the mode
        @(posedge ref_clk);
        rstn <= 1'b0;
        tick(3);
        @(posedge ref_clk);
        rstn <= 1'b1;
        wb(0, 8'h1c, 32'h0, 32'h3);
        tick(4);
        check(ctrl_method, 2'h0, "ctrl_method");
        end_of_test();
    end

    // Watchdog well beyond the few hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        end_of_test();
    end
endmodule : test_fire_mode_trip_supervisor

bind fms_supervisor fms_supervisor_props #(.TRIPS(TRIPS)) u_props (.ref_clk(ref_clk),
    .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .emergency_in(emergency_in), .run_cmd_in(run_cmd_in),
    .trip_in(trip_in), .run_enable(run_enable), .ctrl_method(ctrl_method),
    .freq_ref(freq_ref), .acc_time(acc_time), .dec_time(dec_time), .mf_output(mf_output),
    .mf_relay(mf_relay));
`default_nettype wire
